// *** design/sacc_pkg.sv ***
// sacc_pkg: constants shared by the converter control block
// assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus
package sacc_pkg;

    // ------------------------------------------------------------
    // conversion
    // ------------------------------------------------------------
    localparam int unsigned CODE_W     = 16;
    localparam int unsigned CLK_MHZ    = 10;
    localparam int unsigned TRIAL_NS   = 400;
    localparam int unsigned TRIAL_CYC  = (TRIAL_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0]  TICK_LAST  = 3'(TRIAL_CYC - 1);
    localparam logic [3:0]  BIT_MSB    = 4'hF;
    localparam logic [15:0] CODE_ZERO  = 16'h0000;
    localparam logic [15:0] CODE_MID   = 16'h8000;
    localparam logic [15:0] CODE_FULL  = 16'hFFFF;

    // ------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------
    localparam int unsigned FRAME_BITS = 24;
    localparam logic [4:0]  CMD_BITS   = 5'h08;
    localparam logic [4:0]  FRAME_LAST = 5'h18;
    localparam logic [7:0]  CMD_REG_RD = 8'h54;

    // ------------------------------------------------------------
    // register map, byte offsets
    // ------------------------------------------------------------
    localparam logic [5:0]  OFS_CTRL    = 6'h00;
    localparam logic [5:0]  OFS_CONFIG  = 6'h04;
    localparam logic [5:0]  OFS_RESULT  = 6'h08;
    localparam logic [5:0]  OFS_IRQ_ST  = 6'h0C;
    localparam logic [5:0]  OFS_IRQ_EN  = 6'h10;
    localparam logic [5:0]  OFS_IRQ_CLR = 6'h14;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // interrupt bits: conversion done, overvoltage, frame done
    localparam int unsigned IRQ_W      = 3;
    localparam int unsigned IRQ_DONE   = 0;
    localparam int unsigned IRQ_OV     = 1;
    localparam int unsigned IRQ_FRAME  = 2;
    localparam logic [2:0]  IRQ_RST    = 3'h0;
    localparam logic        CTRL_RST   = 1'h0;
    localparam logic        OV_N_RST   = 1'h1;

    typedef enum logic [1:0] {ST_TRACK, ST_TRIAL, ST_DONE} sacc_state_t;

endpackage

// *** design/sacc_link_if.sv ***
// sacc_link_if: words and events between control core and serial port
// assumes both ends run on the system clock
`timescale 1ns/1ps
`default_nettype none
interface sacc_link_if;
    logic [23:0] word;         // word shifted out in the next frame
    logic        frame_start;  // one-cycle pulse, select asserted
    logic        frame_end;    // one-cycle pulse, full frame done
    logic [7:0]  cmd;          // first eight bits taken in on sdi
    modport core (output word, input frame_start, frame_end, cmd);
    modport port (input word, output frame_start, frame_end, cmd);
endinterface
`default_nettype wire

// *** design/sacc_sync.sv ***
// sacc_sync: two-stage synchroniser for a group of pin levels
// assumes the inputs are asynchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
module sacc_sync #(
    parameter int unsigned W            = 1,
    parameter logic [W-1:0] RST_VAL     = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    // first stage is read only by the second
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_r <= RST_VAL;
            o_q    <= RST_VAL;
        end
        else
        begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule // sacc_sync
`default_nettype wire

// *** design/sacc_serial.sv ***
// sacc_serial: 4-wire readout port, sampled on the system clock
// assumes sck, sdi and cs_n already synchronised; sck period >> clock
`timescale 1ns/1ps
`default_nettype none
module sacc_serial (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_sck,
    input  wire logic i_sdi,
    input  wire logic i_cs_n,
    output var  logic o_sdo,
    output var  logic o_sdo_oe,
    sacc_link_if.port lk
);
    logic        sck_d_r;
    logic        cs_d_r;
    logic [23:0] sh_r;
    logic [7:0]  cmd_r;
    logic [4:0]  cnt_r;
    logic        sck_rise;
    logic        sck_fall;

    localparam logic [4:0] FRAME_LAST_L = sacc_pkg::FRAME_LAST;

    // edges found from the already synchronised levels
    assign sck_rise       = i_sck & ~sck_d_r;
    assign sck_fall       = ~i_sck & sck_d_r;
    assign lk.frame_start = ~i_cs_n & cs_d_r;
    assign lk.frame_end   = i_cs_n & ~cs_d_r & (cnt_r == FRAME_LAST_L);
    assign lk.cmd         = cmd_r;
    assign o_sdo          = sh_r[23];
    assign o_sdo_oe       = ~cs_d_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sck_d_r <= 1'b0;
            cs_d_r  <= 1'b1;
        end
        else
        begin
            sck_d_r <= i_sck;
            cs_d_r  <= i_cs_n;
        end
    end

    // word loads at select, shifts on falling sck so host samples rising
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sh_r  <= 24'h000000;
            cmd_r <= 8'h00;
            cnt_r <= 5'h00;
        end
        else if (lk.frame_start)
        begin
            sh_r  <= lk.word;
            cmd_r <= 8'h00;
            cnt_r <= 5'h00;
        end
        else if (!i_cs_n)
        begin
            if (sck_rise && cnt_r != FRAME_LAST_L)
                cnt_r <= cnt_r + 5'h01;
            if (sck_rise && cnt_r < sacc_pkg::CMD_BITS)
                cmd_r <= {cmd_r[6:0], i_sdi};
            if (sck_fall && cnt_r != 5'h00)
                sh_r <= {sh_r[22:0], 1'b0};
        end
    end
endmodule // sacc_serial
`default_nettype wire

// *** design/sacc_top.sv ***
// sacc_top: successive approximation control, flag and register file
// assumes an analog comparator, dac switch array and clamp detector
// outside; all their levels and the host pins are asynchronous
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
// Function
// - rising convert_start ends tracking, holds the sample, starts a run
// - sixteen binary-weighted trials, most significant bit first
// - after the last trial the code is stored and busy drops
// - trials paced by an internal divider, never by the serial clock
// - code is straight binary: zero, midscale, all ones at top
// - span compression bit maps central part of span to full code
// - over-range input saturates to all ones
// - under-range input saturates to all zeros
// - input above reference plus 0.4 V is an overvoltage
// - active clamp records the event in the overvoltage flag
// - overvoltage flag reads zero when an event occurred
// - flag sticky; cleared only by a read after the condition ends
// - flag reachable by serial register read and with data status
// - result read after a run belongs to that same sample
module sacc_top #(
    parameter int unsigned ADDR_W = 6
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_convert_start,
    input  wire logic              i_comp_high,
    input  wire logic              i_clamp_active,
    input  wire logic              i_sck,
    input  wire logic              i_sdi,
    input  wire logic              i_cs_n,
    output var  logic              o_sdo,
    output var  logic              o_sdo_oe,
    output var  logic              o_busy,
    output var  logic              o_track,
    output var  logic [15:0]       o_dac_bits,
    output var  logic              o_span_compress,
    output var  logic              o_irq,
    input  wire logic [ADDR_W-1:0] i_axi_awaddr,
    input  wire logic              i_axi_awvalid,
    output var  logic              o_axi_awready,
    input  wire logic [31:0]       i_axi_wdata,
    input  wire logic [3:0]        i_axi_wstrb,
    input  wire logic              i_axi_wvalid,
    output var  logic              o_axi_wready,
    output var  logic [1:0]        o_axi_bresp,
    output var  logic              o_axi_bvalid,
    input  wire logic              i_axi_bready,
    input  wire logic [ADDR_W-1:0] i_axi_araddr,
    input  wire logic              i_axi_arvalid,
    output var  logic              o_axi_arready,
    output var  logic [31:0]       o_axi_rdata,
    output var  logic [1:0]        o_axi_rresp,
    output var  logic              o_axi_rvalid,
    input  wire logic              i_axi_rready
);
    localparam int CONV_LEN = 16 * sacc_pkg::TRIAL_CYC + 1;
    localparam int RUN_MID  = CONV_LEN - 8;  // busy cycles after the first 8

    // ------------------------------------------------------------
    // pin synchronisers and serial port
    // ------------------------------------------------------------
    logic [5:0] pins_s;
    logic       cnv_s, comp_s, clamp_s, sck_s, sdi_s, cs_n_s;
    sacc_link_if lk ();

    sacc_sync #(.W(6), .RST_VAL(6'h01)) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     ({i_convert_start, i_comp_high, i_clamp_active,
                   i_sck, i_sdi, i_cs_n}),
        .o_q     (pins_s)
    );
    assign {cnv_s, comp_s, clamp_s, sck_s, sdi_s, cs_n_s} = pins_s;

    sacc_serial u_serial (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_sck    (sck_s),
        .i_sdi    (sdi_s),
        .i_cs_n   (cs_n_s),
        .o_sdo    (o_sdo),
        .o_sdo_oe (o_sdo_oe),
        .lk       (lk.port)
    );

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    sacc_pkg::sacc_state_t state_r;
    logic        cnv_d_r, cnv_rise, decide;
    logic [3:0]  bit_r;
    logic [2:0]  tick_r;
    logic [15:0] trial_r, result_r;
    logic        all_hi_r, all_lo_r, span_run_r, ctrl_span_r;

    assign cnv_rise = cnv_s & ~cnv_d_r;
    // the divider paces each trial; the serial clock plays no part
    assign decide   = (state_r == sacc_pkg::ST_TRIAL)
                      & (tick_r == sacc_pkg::TICK_LAST);
    assign o_busy   = (state_r != sacc_pkg::ST_TRACK);
    assign o_track  = (state_r == sacc_pkg::ST_TRACK);
    assign o_dac_bits      = trial_r;
    assign o_span_compress = span_run_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= sacc_pkg::ST_TRACK;
            cnv_d_r <= 1'b0;
            bit_r   <= sacc_pkg::BIT_MSB;
            tick_r  <= 3'h0;
        end
        else
        begin
            cnv_d_r <= cnv_s;
            unique case (state_r)
                sacc_pkg::ST_TRACK:
                    if (cnv_rise)  // edges during a run are ignored
                    begin
                        state_r <= sacc_pkg::ST_TRIAL;
                        bit_r   <= sacc_pkg::BIT_MSB;
                        tick_r  <= 3'h0;
                    end
                sacc_pkg::ST_TRIAL:
                begin
                    tick_r <= decide ? 3'h0 : tick_r + 3'h1;
                    if (decide)
                    begin
                        bit_r <= bit_r - 4'h1;
                        if (bit_r == 4'h0)
                            state_r <= sacc_pkg::ST_DONE;
                    end
                end
                sacc_pkg::ST_DONE:
                    state_r <= sacc_pkg::ST_TRACK;
            endcase
        end
    end

    // straight binary weights
    // comparator high keeps the bit; always high/low saturates
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            trial_r <= sacc_pkg::CODE_ZERO;
        else if (o_track && cnv_rise)
            trial_r <= sacc_pkg::CODE_MID;
        else if (decide)
        begin
            trial_r[bit_r] <= comp_s;
            if (bit_r != 4'h0)
                trial_r[bit_r - 4'h1] <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            all_hi_r <= 1'b0;
            all_lo_r <= 1'b0;
        end
        else if (o_track && cnv_rise)
        begin
            all_hi_r <= 1'b1;
            all_lo_r <= 1'b1;
        end
        else if (decide)
        begin
            all_hi_r <= all_hi_r & comp_s;
            all_lo_r <= all_lo_r & ~comp_s;
        end
    end

    // result is this sample, no pipeline
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            result_r <= sacc_pkg::CODE_ZERO;
        else if (state_r == sacc_pkg::ST_DONE)
            result_r <= trial_r;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            span_run_r <= sacc_pkg::CTRL_RST;
        else if (o_track)
            span_run_r <= ctrl_span_r;
    end

    // ------------------------------------------------------------
    // overvoltage flag and serial word
    // ------------------------------------------------------------
    logic ov_n_r, reg_pend_r, cfg_rd_axi, cfg_rd;
    logic [15:0] cfg_word;

    assign cfg_word = {14'h0000, span_run_r, ov_n_r};
    assign cfg_rd   = cfg_rd_axi | (lk.frame_end & reg_pend_r);
    // status byte carries the flag beside the data
    assign lk.word  = reg_pend_r ? {cfg_word, 8'h00}
                    : {result_r, ov_n_r, span_run_r, o_busy, 5'h00};

    // set wins; read clears only when clamp is off
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ov_n_r <= sacc_pkg::OV_N_RST;
        else if (clamp_s)
            ov_n_r <= 1'b0;
        else if (cfg_rd)
            ov_n_r <= 1'b1;
    end

    // register read command selects next frame's word
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            reg_pend_r <= 1'b0;
        else if (lk.frame_end)
            reg_pend_r <= ~reg_pend_r & (lk.cmd == sacc_pkg::CMD_REG_RD);
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic [2:0] irq_st_r, irq_en_r, irq_set, irq_clr;
    logic       done_pulse;

    assign done_pulse = (state_r == sacc_pkg::ST_DONE);
    assign irq_set    = {lk.frame_end, clamp_s, done_pulse};
    assign o_irq      = |(irq_st_r & irq_en_r);

    // a new event wins over a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            irq_st_r <= sacc_pkg::IRQ_RST;
        else
            irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic              aw_got_r, w_got_r, wr_go, wr_ok;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic              wstrb0_r;
    logic [31:0]       rd_data;
    logic              rd_ok;
    logic [5:0]        wa, ra;

    assign wa            = 6'(awaddr_r);
    assign ra            = 6'(i_axi_araddr);
    assign o_axi_awready = ~aw_got_r & ~o_axi_bvalid;
    assign o_axi_wready  = ~w_got_r & ~o_axi_bvalid;
    assign o_axi_arready = ~o_axi_rvalid;
    assign wr_go         = aw_got_r & w_got_r & ~o_axi_bvalid;
    assign wr_ok         = (wa == sacc_pkg::OFS_CTRL)
                         | (wa == sacc_pkg::OFS_IRQ_EN)
                         | (wa == sacc_pkg::OFS_IRQ_CLR);
    assign irq_clr       = (wr_go && wstrb0_r && wa == sacc_pkg::OFS_IRQ_CLR)
                         ? wdata_r[2:0] : 3'h0;
    assign cfg_rd_axi    = i_axi_arvalid & o_axi_arready
                         & (ra == sacc_pkg::OFS_CONFIG);

    // address and data taken in either order
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            awaddr_r     <= '0;
            wdata_r      <= 32'h00000000;
            wstrb0_r     <= 1'b0;
            o_axi_bvalid <= 1'b0;
            o_axi_bresp  <= sacc_pkg::RESP_OKAY;
        end
        else
        begin
            if (i_axi_awvalid && o_axi_awready)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= i_axi_awaddr;
            end
            if (i_axi_wvalid && o_axi_wready)
            begin
                w_got_r  <= 1'b1;
                wdata_r  <= i_axi_wdata;
                wstrb0_r <= i_axi_wstrb[0];
            end
            if (wr_go)
            begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                o_axi_bvalid <= 1'b1;
                o_axi_bresp  <= wr_ok ? sacc_pkg::RESP_OKAY
                                      : sacc_pkg::RESP_SLVERR;
            end
            else if (i_axi_bready)
                o_axi_bvalid <= 1'b0;
        end
    end

    // software-written controls
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_span_r <= sacc_pkg::CTRL_RST;
            irq_en_r    <= sacc_pkg::IRQ_RST;
        end
        else if (wr_go && wstrb0_r)
        begin
            if (wa == sacc_pkg::OFS_CTRL)
                ctrl_span_r <= wdata_r[0];
            if (wa == sacc_pkg::OFS_IRQ_EN)
                irq_en_r <= wdata_r[2:0];
        end
    end

    // read mux; unmapped or unaligned gives slverr and zero
    always_comb
    begin
        rd_data = 32'h00000000;
        rd_ok   = 1'b1;
        case (ra)
            sacc_pkg::OFS_CTRL:    rd_data = {31'h0, ctrl_span_r};
            sacc_pkg::OFS_CONFIG:  rd_data = {16'h0000, cfg_word};
            sacc_pkg::OFS_RESULT:  rd_data = {16'h0000, result_r};
            sacc_pkg::OFS_IRQ_ST:  rd_data = {29'h0, irq_st_r};
            sacc_pkg::OFS_IRQ_EN:  rd_data = {29'h0, irq_en_r};
            sacc_pkg::OFS_IRQ_CLR: rd_data = 32'h00000000;
            default:               rd_ok   = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_axi_rvalid <= 1'b0;
            o_axi_rdata  <= 32'h00000000;
            o_axi_rresp  <= sacc_pkg::RESP_OKAY;
        end
        else if (i_axi_arvalid && o_axi_arready)
        begin
            o_axi_rvalid <= 1'b1;
            o_axi_rdata  <= rd_data;
            o_axi_rresp  <= rd_ok ? sacc_pkg::RESP_OKAY
                                  : sacc_pkg::RESP_SLVERR;
        end
        else if (i_axi_rready)
            o_axi_rvalid <= 1'b0;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_start;
        o_track && cnv_rise;
    endsequence
    sequence s_run;
        o_busy [*8] ##RUN_MID o_busy ##1 !o_busy;
    endsequence

    property p_start_holds;
        s_start |=> !o_track && o_busy;
    endproperty
    a_start_holds: assert property (p_start_holds)
        else $error("start edge did not end tracking");

    property p_msb_first;
        s_start |=> o_dac_bits == sacc_pkg::CODE_MID;
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first trial is not the top bit");

    property p_run_length;
        s_start |=> s_run;
    endproperty
    a_run_length: assert property (p_run_length)
        else $error("conversion length wrong");

    property p_result_on_end;
        $fell(o_busy) |-> result_r == $past(trial_r) && irq_st_r[0];
    endproperty
    a_result_on_end: assert property (p_result_on_end)
        else $error("result not taken at end of run");

    property p_sat_high;
        state_r == sacc_pkg::ST_DONE && all_hi_r
            |=> result_r == sacc_pkg::CODE_FULL;
    endproperty
    a_sat_high: assert property (p_sat_high)
        else $error("over-range did not give all ones");

    property p_sat_low;
        state_r == sacc_pkg::ST_DONE && all_lo_r
            |=> result_r == sacc_pkg::CODE_ZERO;
    endproperty
    a_sat_low: assert property (p_sat_low)
        else $error("under-range did not give all zeros");

    property p_ov_set;
        clamp_s |=> !ov_n_r;
    endproperty
    a_ov_set: assert property (p_ov_set)
        else $error("clamp did not set flag");

    property p_ov_clear;
        !ov_n_r && !clamp_s && cfg_rd |=> ov_n_r;
    endproperty
    a_ov_clear: assert property (p_ov_clear)
        else $error("read with clamp off did not clear flag");

    property p_ov_sticky;
        !ov_n_r && !cfg_rd |=> !ov_n_r;
    endproperty
    a_ov_sticky: assert property (p_ov_sticky)
        else $error("flag cleared without a read");

    property p_span_frozen;
        o_busy && $past(o_busy) |-> $stable(o_span_compress);
    endproperty
    a_span_frozen: assert property (p_span_frozen)
        else $error("span mode changed during a run");

    property p_status_ov;
        !reg_pend_r |-> lk.word[7] == ov_n_r;
    endproperty
    a_status_ov: assert property (p_status_ov)
        else $error("status byte lacks the flag");
endmodule // sacc_top
`default_nettype wire

// *** verif/sacc_host_model.sv ***
// sacc_host_model: serial host shifting 24-bit frames out of the port
// assumes the caller starts a frame only while busy is low
`timescale 1ns/1ps
`default_nettype none
module sacc_host_model (
    output var  logic o_sck,
    output var  logic o_sdi,
    output var  logic o_cs_n,
    input  wire logic i_sdo
);
    // link clock parked low, select high, outside frames
    initial
    begin
        o_sck = 1'b0;
        o_sdi = 1'b0;
        o_cs_n = 1'b1;
    end
    // frame after busy
    // 800 ns link clock; sdi toggles after the command so no stale level
    task automatic frame(input logic [7:0] cmd, output logic [23:0] got);
        #10;  // keep pin changes off the system clock edge
        o_cs_n = 1'b0;
        #1200;
        for (int i = 0; i < 24; i++)
        begin
            o_sdi = (i < 8) ? cmd[7-i] : ~o_sdi;
            #400 o_sck = 1'b1;
            got = {got[22:0], i_sdo};
            #400 o_sck = 1'b0;
        end
        o_cs_n = 1'b1;
        #1000;
    endtask
endmodule // sacc_host_model
`default_nettype wire

// *** verif/sacc_top_bench.sv ***
// sacc_top_bench: conversion, flag, serial and register checks
// assumes an ideal comparator: keep bit while sample >= trial level
`timescale 1ns/1ps
`default_nettype none
module sacc_top_bench;
    logic i_clk = 0, i_rst_n = 0, start = 0, comp = 0, clamp = 0;
    logic sck, sdi, cs_n, sdo, oe, busy, track, span, irq, awr, wr, bv;
    logic arr, rv, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [15:0] dac, sample = '0;
    logic [5:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] bresp, rresp;
    logic [23:0] word;
    logic [15:0] codes [4] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h5A3C};
    int fail_count = 0, checked = 0, n;
    sacc_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_convert_start(start),
        .i_comp_high(comp), .i_clamp_active(clamp), .i_sck(sck), .i_sdi(sdi),
        .i_cs_n(cs_n), .o_sdo(sdo), .o_sdo_oe(oe), .o_busy(busy),
        .o_track(track), .o_dac_bits(dac), .o_span_compress(span),
        .o_irq(irq), .i_axi_awaddr(awaddr), .i_axi_awvalid(awv),
        .o_axi_awready(awr), .i_axi_wdata(wdata), .i_axi_wstrb(4'hF),
        .i_axi_wvalid(wv), .o_axi_wready(wr), .o_axi_bresp(bresp),
        .o_axi_bvalid(bv), .i_axi_bready(bready), .i_axi_araddr(araddr),
        .i_axi_arvalid(arv), .o_axi_arready(arr), .o_axi_rdata(rdata),
        .o_axi_rresp(rresp), .o_axi_rvalid(rv), .i_axi_rready(rready));
    sacc_host_model u_host (.o_sck(sck), .o_sdi(sdi), .o_cs_n(cs_n),
        .i_sdo(sdo));
    // clock and comparator stand-in, one cycle of settling lag
    initial
        forever #50 i_clk = ~i_clk;
    always @(posedge i_clk)
        comp <= (sample >= dac);
    task automatic chk(input string what, input logic [31:0] exp, got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // axi write: both channels offered, each dropped once taken
    task automatic axw(input logic [5:0] a, input logic [31:0] d,
                       input logic [1:0] resp);
        @(posedge i_clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        bready <= 1'b0;
        chk("bresp", 32'(resp), 32'(bresp));
    endtask
    task automatic axr(input logic [5:0] a, input logic [31:0] exp,
                       input logic [1:0] resp);
        @(posedge i_clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rready <= 1'b0;
        chk("rresp", 32'(resp), 32'(rresp));
        chk("rdata", exp, rdata);
    endtask
    // one run: busy counted from first sampled high to first low
    task automatic conv(input logic [15:0] s);
        sample <= s;
        start <= 1'b1;
        n = 0;
        do @(posedge i_clk); while (!busy && ++n < 20);
        start <= 1'b0;
        n = 1;  // the first busy cycle was seen by the loop above
        do @(posedge i_clk); while (busy && ++n < 200);
        chk("busy cycles", 16 * sacc_pkg::TRIAL_CYC + 1, n);
        axr(sacc_pkg::OFS_RESULT, 32'(s), sacc_pkg::RESP_OKAY);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #2000000;
        fail_count++;
        $display("Error watchdog expected end seen hang");
        final_report;
    end
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        chk("track", 1, track);
        chk("sdo_oe idle", 0, oe);
        foreach (codes[i]) conv(codes[i]);
        chk("irq masked", 0, irq);
        axw(sacc_pkg::OFS_IRQ_EN, 32'h1, sacc_pkg::RESP_OKAY);
        chk("irq", 1, irq);
        axw(sacc_pkg::OFS_IRQ_CLR, 32'h1, sacc_pkg::RESP_OKAY);
        chk("irq cleared", 0, irq);
        $display("test conversion done");
        clamp <= 1'b1;
        repeat (6) @(posedge i_clk);
        axr(sacc_pkg::OFS_CONFIG, 32'h0, sacc_pkg::RESP_OKAY);
        u_host.frame(8'h00, word);
        chk("status frame", {16'h5A3C, 8'h00}, 32'(word));
        u_host.frame(sacc_pkg::CMD_REG_RD, word);
        u_host.frame(8'h00, word);
        chk("flag frame", 32'h0, 32'(word));
        clamp <= 1'b0;
        repeat (6) @(posedge i_clk);
        axr(sacc_pkg::OFS_CONFIG, 32'h0, sacc_pkg::RESP_OKAY);
        axr(sacc_pkg::OFS_CONFIG, 32'h1, sacc_pkg::RESP_OKAY);
        $display("test overvoltage done");
        axw(sacc_pkg::OFS_CTRL, 32'h1, sacc_pkg::RESP_OKAY);
        @(posedge i_clk);  // span mode is taken over one edge later
        chk("span", 1, span);
        axw(sacc_pkg::OFS_RESULT, 32'h1, sacc_pkg::RESP_SLVERR);
        axr(6'h3C, 32'h0, sacc_pkg::RESP_SLVERR);
        $display("test registers done");
        final_report;
    end
endmodule // sacc_top_bench
`default_nettype wire
